// File: lvt_map.svh
// Register offsets, field positions, reset values, mode codes and timing counts of the timer.
`ifndef LVT_MAP_SVH
`define LVT_MAP_SVH
`define LVT_OFF_CONTROL   12'h000
`define LVT_OFF_MODE      12'h004
`define LVT_OFF_PERIOD    12'h008
`define LVT_OFF_COMPARE   12'h00C
`define LVT_OFF_STATUS    12'h010
`define LVT_ON_BIT        7
`define LVT_PRE_HI        6
`define LVT_PRE_LO        4
`define LVT_POST_HI       3
`define LVT_POST_LO       0
`define LVT_RST_CONTROL   8'h00
`define LVT_RST_MODE      5'h00
`define LVT_RST_PERIOD    8'hFF
`define LVT_RST_COMPARE   8'h00
`define LVT_MODE_FREE     5'h00
`define LVT_MODE_LVL_LOW  5'h06
`define LVT_MODE_LVL_HIGH 5'h07
`define LVT_MODE_ONESHOT  5'h08
`define LVT_HOLD_DELAY    2
`define LVT_RESP_OKAY     2'h0
`define LVT_RESP_SLVERR   2'h2
`endif

// File: lvt_pkg.sv
// Types shared by the level-limit period timer.
package lvt_pkg;
    typedef struct packed {
        logic       on;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } lvt_control_t;

    typedef enum logic [1:0] {
        LVT_ST_OFF  = 2'b00,
        LVT_ST_RUN  = 2'b01,
        LVT_ST_HOLD = 2'b11
    } lvt_state_t;

    typedef struct packed {
        logic       pwm_out;
        logic       postscaled_match;
        logic [7:0] count;
    } lvt_timer_out_t;
endpackage

// File: lvt_timer.sv
// Level-limit period timer with prescaler, postscaler, PWM time base and AXI4-Lite registers.
//
// Operation
// - Mode 00110 holds the counter in reset while the external reset signal is low.
// - Mode 00111 holds the counter in reset while the external reset signal is high.
// - Counter stays reset for as long as the external reset stays active.
// - With the run bit clear the external reset signal is ignored.
// - PWM goes high when counting starts, low at the compare match or when the run bit is cleared.
// - Timer resets at period match, or two clocks after external reset activates.
// - Counting and PWM high resume after period match, or two clocks after release.
// - External reset arriving while PWM is high keeps PWM high through it.
// - Run bit is bit 7, software written, cleared by hardware in one-shot mode.
// - Prescale select bits 6 to 4 divide by two to the field value.
// - Postscale select bits 3 to 0 give a ratio of field value plus one.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "lvt_map.svh"

module lvt_timer #(
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // External reset source
    input  wire logic                  external_reset_signal,
    // Timer outputs toward the compare/PWM unit
    output lvt_pkg::lvt_timer_out_t    timer_out
);

    // Register state.
    lvt_pkg::lvt_control_t timer_control;
    logic [4:0]            mode;
    logic [COUNT_W-1:0]    period_register;
    logic [COUNT_W-1:0]    compare_pulse_width;

    // Write channel holding registers.
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;

    // Timer state.
    lvt_pkg::lvt_state_t state;
    lvt_pkg::lvt_state_t next_state;
    logic [6:0]          pre_cnt;
    logic [6:0]          pre_limit;
    logic                tick;
    logic [1:0]          ers_dly;
    logic [1:0]          next_ers_dly;
    logic                ers_active;
    logic [COUNT_W-1:0]  count;
    logic [3:0]          post_cnt;
    logic                period_match;
    logic                pwm;
    logic                post_pulse;
    logic                hw_clear_on;

    // AXI4-Lite write path: address and data are taken in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LVT_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr)
                `LVT_OFF_CONTROL, `LVT_OFF_MODE, `LVT_OFF_PERIOD, `LVT_OFF_COMPARE,
                `LVT_OFF_STATUS: s_axi_bresp <= `LVT_RESP_OKAY;
                default:         s_axi_bresp <= `LVT_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A software write of the control word wins over the hardware clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control <= `LVT_RST_CONTROL;
        end else if (do_write && w_strb[0] && aw_addr == `LVT_OFF_CONTROL) begin
            timer_control.on               <= w_data[`LVT_ON_BIT];
            timer_control.prescale_select  <= w_data[`LVT_PRE_HI:`LVT_PRE_LO];
            timer_control.postscale_select <= w_data[`LVT_POST_HI:`LVT_POST_LO];
        end else if (hw_clear_on) begin
            timer_control.on <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode                <= `LVT_RST_MODE;
            period_register     <= COUNT_W'(`LVT_RST_PERIOD);
            compare_pulse_width <= COUNT_W'(`LVT_RST_COMPARE);
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == `LVT_OFF_MODE) begin
                mode <= w_data[4:0];
            end
            if (aw_addr == `LVT_OFF_PERIOD) begin
                period_register <= w_data[COUNT_W-1:0];
            end
            if (aw_addr == `LVT_OFF_COMPARE) begin
                compare_pulse_width <= w_data[COUNT_W-1:0];
            end
        end
    end

    // AXI4-Lite read path: one read at a time, answered the cycle after the address.
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `LVT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `LVT_RESP_OKAY;
            unique case (s_axi_araddr)
                `LVT_OFF_CONTROL: s_axi_rdata <= {24'h00_0000, timer_control};
                `LVT_OFF_MODE:    s_axi_rdata <= {27'h000_0000, mode};
                `LVT_OFF_PERIOD:  s_axi_rdata <= 32'(period_register);
                `LVT_OFF_COMPARE: s_axi_rdata <= 32'(compare_pulse_width);
                `LVT_OFF_STATUS:  s_axi_rdata <= {21'h00_0000, state, pwm, 8'(count)};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `LVT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Prescaler: the limit is two to the select value, minus one.
    assign pre_limit = 7'((8'h01 << timer_control.prescale_select) - 8'h01);
    assign tick      = (state != lvt_pkg::LVT_ST_OFF) && (pre_cnt == pre_limit);

    always_ff @(posedge aclk) begin
        if (!aresetn || state == lvt_pkg::LVT_ST_OFF) begin
            pre_cnt <= 7'h00;
        end else if (tick) begin
            pre_cnt <= 7'h00;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // The active level depends on the mode; other modes never hold the counter.
    always_comb begin
        unique case (mode)
            `LVT_MODE_LVL_LOW:  ers_active = !external_reset_signal;
            `LVT_MODE_LVL_HIGH: ers_active = external_reset_signal;
            default:            ers_active = 1'b0;
        endcase
    end

    // The level passes two timer clocks before it holds or releases the counter.
    assign next_ers_dly = {ers_dly[0], ers_active};

    always_ff @(posedge aclk) begin
        if (!aresetn || !timer_control.on) begin
            ers_dly <= 2'b00;
        end else if (tick) begin
            ers_dly <= next_ers_dly;
        end
    end

    // Hold is a level, re-evaluated each timer clock, not a single reset on an edge.
    always_comb begin
        next_state = state;
        if (!timer_control.on) begin
            next_state = lvt_pkg::LVT_ST_OFF;
        end else if (state == lvt_pkg::LVT_ST_OFF) begin
            next_state = lvt_pkg::LVT_ST_RUN;
        end else if (tick) begin
            next_state = next_ers_dly[`LVT_HOLD_DELAY-1] ? lvt_pkg::LVT_ST_HOLD
                                                        : lvt_pkg::LVT_ST_RUN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= lvt_pkg::LVT_ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    assign period_match = tick && state == lvt_pkg::LVT_ST_RUN && count == period_register;
    assign hw_clear_on  = period_match && mode == `LVT_MODE_ONESHOT;

    always_ff @(posedge aclk) begin
        if (!aresetn || state == lvt_pkg::LVT_ST_OFF) begin
            count <= '0;
        end else if (tick) begin
            // Release restarts from zero with the output high, as a period match does.
            if (next_ers_dly[`LVT_HOLD_DELAY-1] || period_match) begin
                count <= '0;
            end else if (state == lvt_pkg::LVT_ST_HOLD) begin
                count <= '0;
            end else begin
                count <= count + COUNT_W'(1);
            end
        end
    end

    // The PWM level is left alone while held, so a high output stays high.
    always_ff @(posedge aclk) begin
        if (!aresetn || !timer_control.on) begin
            pwm <= 1'b0;
        end else if (state == lvt_pkg::LVT_ST_OFF) begin
            pwm <= 1'b1;
        end else if (tick) begin
            if (next_ers_dly[`LVT_HOLD_DELAY-1]) begin
                pwm <= pwm;
            end else if (period_match || state == lvt_pkg::LVT_ST_HOLD) begin
                pwm <= 1'b1;
            end else if (count == compare_pulse_width) begin
                pwm <= 1'b0;
            end
        end
    end

    // Postscaler: one output pulse every select-plus-one period matches.
    always_ff @(posedge aclk) begin
        if (!aresetn || state == lvt_pkg::LVT_ST_OFF) begin
            post_cnt   <= 4'h0;
            post_pulse <= 1'b0;
        end else begin
            post_pulse <= 1'b0;
            if (period_match) begin
                if (post_cnt == timer_control.postscale_select) begin
                    post_cnt   <= 4'h0;
                    post_pulse <= 1'b1;
                end else begin
                    post_cnt <= post_cnt + 4'h1;
                end
            end
        end
    end

    assign timer_out.pwm_out          = pwm;
    assign timer_out.postscaled_match = post_pulse;
    assign timer_out.count            = 8'(count);

endmodule

// File: lvt_ers_src.sv
// Behavioural source of the external reset level seen by the timer.
`timescale 1ns/1ps
module lvt_ers_src (
    // Clock, level request and driven level
    input  wire logic aclk,
    input  wire logic req,
    output logic      external_reset_signal
);
    // Retimed so the level moves just after an edge, as real logic would.
    always_ff @(posedge aclk) begin
        external_reset_signal <= req;
    end
endmodule

// File: lvt_timer_chk.sv
// Port-level assertions of the level-limit period timer.
`timescale 1ns/1ps
module lvt_timer_chk (
    // Clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // Register bus handshakes
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    // Timer outputs
    input wire lvt_pkg::lvt_timer_out_t timer_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
        && !s_axi_rvalid && timer_out == '0) else $error("outputs not cleared");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_count_step: assert property ($changed(timer_out.count) |->
        timer_out.count == 8'h00 || timer_out.count == $past(timer_out.count) + 8'h01)
        else $error("count jumped");
    a_pwm_rise: assert property ($rose(timer_out.pwm_out) |-> timer_out.count == 8'h00)
        else $error("pwm rose mid period");
endmodule

bind lvt_timer lvt_timer_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .timer_out);

// File: lvt_timer_tb_top.sv
// Self-checking bench of the level-limit period timer.
`timescale 1ns/1ps
`include "lvt_map.svh"
module lvt_timer_tb_top;
    logic                    aclk, aresetn, ers_req, ers, bvalid, rvalid;
    logic                    awvalid, wvalid, bready, arvalid, rready, awready, wready, arready;
    logic [11:0]             awaddr, araddr;
    logic [31:0]             wdata, rdata, d;
    logic [1:0]              bresp, rresp, r;
    logic [7:0]              c;
    int                      err_total, n_checks, n, i;
    lvt_pkg::lvt_timer_out_t tout;

    lvt_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .external_reset_signal(ers), .timer_out(tout));
    lvt_ers_src ers_u (.aclk(aclk), .req(ers_req), .external_reset_signal(ers));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Readies are sampled at the edge, before that edge's updates land.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic t_regs;
        logic [31:0] ex [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000};
        for (i = 0; i < 4; i++) begin
            rd(12'(i * 4));
            chk("reset value", d, ex[i]);
        end
        wr(`LVT_OFF_CONTROL, 32'hFFFF_FF35);
        rd(`LVT_OFF_CONTROL);
        chk("control fields", d, 32'h0000_0035);
        rd(12'h014);
        chk("unmapped rresp", {30'h0, r}, {30'h0, `LVT_RESP_SLVERR});
        wr(12'h014, 32'h0000_0001);
        chk("unmapped bresp", {30'h0, r}, {30'h0, `LVT_RESP_SLVERR});
        $display("regs done");
    endtask

    task automatic t_wave;
        wr(`LVT_OFF_PERIOD, 32'h0000_0003);
        wr(`LVT_OFF_COMPARE, 32'h0000_0001);
        wr(`LVT_OFF_CONTROL, 32'h0000_0080);
        @(negedge aclk);
        while (tout.count !== 8'h03) @(negedge aclk);
        for (i = 0; i < 5; i++) begin
            @(negedge aclk);
            chk("count", {24'h0, tout.count}, 32'(i % 4));
            chk("pwm", {31'h0, tout.pwm_out}, 32'(i % 4 < 2));
        end
        $display("wave done");
    endtask

    task automatic t_pre;
        wr(`LVT_OFF_PERIOD, 32'h0000_00FF);
        for (i = 0; i < 8; i++) begin
            wr(`LVT_OFF_CONTROL, 32'h0000_0080 | 32'(i << 4));
            @(negedge aclk);
            c = tout.count;
            while (tout.count === c) @(negedge aclk);
            c = tout.count;
            n = 0;
            while (tout.count === c) begin
                @(negedge aclk);
                n++;
            end
            chk("tick gap", 32'(n), 32'(1 << i));
        end
        $display("prescale done");
    endtask

    task automatic t_post;
        wr(`LVT_OFF_PERIOD, 32'h0000_0001);
        for (i = 0; i < 16; i++) begin
            wr(`LVT_OFF_CONTROL, 32'h0000_0000);
            wr(`LVT_OFF_CONTROL, 32'h0000_0080 | 32'(i));
            @(negedge aclk);
            while (tout.postscaled_match !== 1'b1) @(negedge aclk);
            n = 0;
            do begin
                @(negedge aclk);
                n++;
            end while (tout.postscaled_match !== 1'b1);
            chk("pulse gap", 32'(n), 32'(2 * i + 2));
        end
        $display("postscale done");
    endtask

    task automatic t_hold;
        wr(`LVT_OFF_CONTROL, 32'h0000_0000);
        wr(`LVT_OFF_PERIOD, 32'h0000_00FF);
        wr(`LVT_OFF_COMPARE, 32'h0000_0080);
        wr(`LVT_OFF_MODE, {27'h0, `LVT_MODE_LVL_HIGH});
        wr(`LVT_OFF_CONTROL, 32'h0000_0080);
        @(negedge aclk);
        while (tout.count !== 8'h10) @(negedge aclk);
        @(posedge aclk);
        ers_req <= 1'b1;
        repeat (8) @(negedge aclk);
        chk("held", {24'h0, tout.count}, 32'h0);
        repeat (20) @(negedge aclk);
        chk("still held", {24'h0, tout.count}, 32'h0);
        chk("pwm kept", {31'h0, tout.pwm_out}, 32'h1);
        rd(`LVT_OFF_STATUS);
        chk("hold state", {30'h0, d[10:9]}, 32'h3);
        ers_req <= 1'b0;
        repeat (8) @(negedge aclk);
        chk("resumed", 32'(tout.count inside {[8'h01:8'h07]}), 32'h1);
        wr(`LVT_OFF_MODE, {27'h0, `LVT_MODE_LVL_LOW});
        repeat (8) @(negedge aclk);
        chk("low held", {24'h0, tout.count}, 32'h0);
        @(posedge aclk);
        ers_req <= 1'b1;
        repeat (8) @(negedge aclk);
        chk("low freed", 32'(tout.count inside {[8'h01:8'h07]}), 32'h1);
        wr(`LVT_OFF_COMPARE, 32'h0000_0008);
        @(negedge aclk);
        while (tout.count !== 8'h0A) @(negedge aclk);
        @(posedge aclk);
        ers_req <= 1'b0;
        repeat (8) @(negedge aclk);
        chk("low pwm held", {31'h0, tout.pwm_out}, 32'h0);
        @(posedge aclk);
        ers_req <= 1'b1;
        repeat (4) @(negedge aclk);
        chk("release count", {24'h0, tout.count}, 32'h0);
        chk("release pwm", {31'h0, tout.pwm_out}, 32'h1);
        wr(`LVT_OFF_CONTROL, 32'h0000_0000);
        ers_req <= 1'b0;
        repeat (8) @(negedge aclk);
        rd(`LVT_OFF_STATUS);
        chk("off status", d, 32'h0);
        $display("hold done");
    endtask

    task automatic t_shot;
        wr(`LVT_OFF_MODE, {27'h0, `LVT_MODE_ONESHOT});
        wr(`LVT_OFF_PERIOD, 32'h0000_0003);
        wr(`LVT_OFF_CONTROL, 32'h0000_0080);
        repeat (20) @(negedge aclk);
        rd(`LVT_OFF_CONTROL);
        chk("auto clear", d, 32'h0);
        chk("stopped", {24'h0, tout.count}, 32'h0);
        $display("one-shot done");
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ers_req} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_wave;
        t_pre;
        t_post;
        t_hold;
        t_shot;
        print_verdict;
    end

    // The longest test needs under a thousand cycles, so this only trips on a hang.
    initial begin
        repeat (50000) @(posedge aclk);
        err_total++;
        print_verdict;
    end
endmodule
